// ### qudc_pkg.sv
/*
  Package of the quadrature up/down counter: register offsets, field
  positions, reset values, modes and timing constants.
  Assumes a 32-bit AHB-Lite register bus with one word per register.
*/
package qudc_pkg;

  // Register byte offsets
  localparam logic [7:0] QUDC_CONFIG_OFS  = 8'h00; // Mode, enables, zero action
  localparam logic [7:0] QUDC_DEBOUNCE_OFS = 8'h04; // Debounce length in cycles
  localparam logic [7:0] QUDC_COUNT_OFS   = 8'h08; // Count value, read/write
  localparam logic [7:0] QUDC_MAX_OFS     = 8'h0C; // Upper boundary
  localparam logic [7:0] QUDC_MIN_OFS     = 8'h10; // Lower boundary
  localparam logic [7:0] QUDC_STATUS_OFS  = 8'h14; // Sticky event bits, read only
  localparam logic [7:0] QUDC_CLEAR_OFS   = 8'h18; // Write one to clear, write only
  localparam logic [7:0] QUDC_IRQEN_OFS   = 8'h1C; // Interrupt enable
  localparam logic [7:0] QUDC_INPUTS_OFS  = 8'h20; // Filtered input levels

  // Config field positions
  localparam int QUDC_CFG_EN_BIT     = 0;  // Counter enable
  localparam int QUDC_CFG_MODE_LSB   = 1;  // Mode field, 3 bits
  localparam int QUDC_CFG_AUTOZ_BIT  = 4;  // Zero the count on boundary exceed
  localparam int QUDC_CFG_ZMRK_BIT   = 5;  // Zero the count on zero marker edge
  localparam int QUDC_CFG_INVDIR_BIT = 6;  // Invert counting direction

  // Status bit positions
  localparam int QUDC_ST_UP_BIT   = 0; // Counted up
  localparam int QUDC_ST_DOWN_BIT = 1; // Counted down
  localparam int QUDC_ST_MAX_BIT  = 2; // Upper boundary exceeded
  localparam int QUDC_ST_MIN_BIT  = 3; // Lower boundary exceeded
  localparam int QUDC_ST_ZERO_BIT = 4; // Zero marker edge seen
  localparam int QUDC_ST_W        = 5; // Number of status bits

  // Reset values
  localparam logic [31:0] QUDC_CONFIG_RST   = 32'h0000_0000;
  localparam logic [31:0] QUDC_DEBOUNCE_RST = 32'h0000_0004;
  localparam logic [31:0] QUDC_MAX_RST      = 32'h7FFF_FFFF;
  localparam logic [31:0] QUDC_MIN_RST      = 32'h8000_0000;

  // Counting modes
  typedef enum logic [2:0] {
    QUDC_QUAD   = 3'b000, // Quadrature decode
    QUDC_BIN    = 3'b001, // 2-bit binary code decode
    QUDC_UDCNT  = 3'b010, // Up edge on a, down edge on b
    QUDC_DIRCNT = 3'b011  // Edge on a counts, level of b is direction
  } qudc_mode_t;

  // Timing: clock figures and the shortest debounce
  localparam int QUDC_CLK_HZ       = 20_000_000; // System clock rate
  localparam int QUDC_DEB_MIN_NS   = 100;        // Least stable time
  localparam int QUDC_DEB_MIN_CYC  = (QUDC_DEB_MIN_NS * (QUDC_CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : qudc_pkg

// ### qudc_counter.sv
/*
  Quadrature up/down counter with debounced inputs, boundary compare,
  auto-zero, zero marker and an AHB-Lite register slave.
  Assumes pins asynchronous to hclk and a single-word AHB-Lite master.
  Limitation: a pin level that stands for fewer cycles than the
  debounce setting is lost; no count is guessed for it.
*/
`timescale 1ns/1ps

module qudc_counter
  import qudc_pkg::*;
#(
  parameter int DEB_W = 16 // Width of debounce counter
) (
  input  wire logic        hclk,           // System clock
  input  wire logic        hresetn,        // Asynchronous reset, active low
  input  wire logic        hsel,           // Slave select
  input  wire logic [31:0] haddr,          // Address
  input  wire logic [1:0]  htrans,         // Transfer type
  input  wire logic        hwrite,         // Write flag
  input  wire logic [2:0]  hsize,          // Transfer size
  input  wire logic [31:0] hwdata,         // Write data
  input  wire logic        hready,         // Bus ready in
  output logic      [31:0] hrdata,         // Read data
  output logic             hreadyout,      // Slave ready
  output logic             hresp,          // Always OKAY
  input  wire logic        pin_a,          // Counter input a
  input  wire logic        pin_b,          // Counter input b
  input  wire logic        pin_zero,       // Zero marker or push button
  output logic             count_up_evt,   // Up event to interval timer
  output logic             count_down_evt, // Down event to interval timer
  output logic             irq             // Level interrupt
);

  // Elaboration check: the stability counter must fit the register word
  // and hold at least the smallest useful count
  // Widths outside this range are refused before any logic is built
  if (DEB_W < 2 || DEB_W > 32) begin : g_deb_w_check
    $error("DEB_W out of range");
  end

  // Register state
  // Software visible state; config, debounce and bounds reset to the package values, count, status and enables to zero
  logic [31:0]          config_reg;     // Configuration
  logic [DEB_W-1:0]     debounce_reg;   // Debounce length
  logic [31:0]          count;          // Position count
  logic [31:0]          max_bound;      // Upper boundary
  logic [31:0]          min_bound;      // Lower boundary
  logic [QUDC_ST_W-1:0] status;         // Sticky events
  logic [QUDC_ST_W-1:0] irq_en;         // Interrupt enables

  // Bus pipeline
  // Held from the address phase into the data phase
  logic       ph_valid;  // Data phase pending
  logic       ph_write;  // Pending phase is a write
  logic [7:0] ph_addr;   // Pending address

  // Input synchronisers and filters
  // Index 0 is pin a, 1 is pin b, 2 is the zero pin
  logic [2:0] sync1;     // First stage
  logic [2:0] sync2;     // Second stage
  logic [2:0] filt;      // Debounced levels
  logic [2:0] filt_d;    // Previous debounced levels
  logic [DEB_W-1:0] stab_cnt [3]; // Stable time per input

  // Decoded controls
  // Combinational, settled well before each edge
  logic       enable;    // Counter enabled
  qudc_mode_t mode;      // Counting mode
  logic       up_step;   // Count up this cycle
  logic       dn_step;   // Count down this cycle
  logic       zero_edge; // Rising edge of zero marker
  logic       over_max;  // Count above upper bound
  logic       under_min; // Count below lower bound
  logic       wr_cfg;    // Bus write strobe
  logic [QUDC_ST_W-1:0] set_ev;  // Events this cycle
  logic [QUDC_ST_W-1:0] clr_req; // Clear request this cycle

  // Signed step of a 2-bit code change: +1, -1 or none
  // Gray codes are turned to binary first, so both decoders share one
  // subtraction; a jump of two is ambiguous and counts nothing
  function automatic logic [1:0] qudc_step(input logic [1:0] prev, input logic [1:0] cur, input logic gray);
    logic [1:0] p;
    logic [1:0] c;
    logic [1:0] d;
    p = gray ? {prev[1], prev[1] ^ prev[0]} : prev;
    c = gray ? {cur[1], cur[1] ^ cur[0]} : cur;
    d = c - p;
    if (d == 2'd1) begin
      qudc_step = 2'b01;   // Up
    end else if (d == 2'd3) begin
      qudc_step = 2'b10;   // Down
    end else begin
      qudc_step = 2'b00;   // No move or illegal jump
    end
  endfunction

  // Config fields used by the decoders
  assign enable = config_reg[QUDC_CFG_EN_BIT];
  assign mode   = qudc_mode_t'(config_reg[QUDC_CFG_MODE_LSB +: 3]);

  // Two-flop synchronisers on all pins
  // Only the second stage reads the first, so a metastable first stage
  // never reaches the filters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {pin_zero, pin_b, pin_a};
      sync2 <= sync1;
    end
  end

  // Debounce filters: new level taken after stable time
  // Each input has its own stability counter. A pin that returns to the
  // filtered level restarts the count, so glitches shorter than the
  // setting never reach the decoders. A setting of zero or one takes
  // a new level after one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        stab_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sync2[i] == filt[i]) begin
          stab_cnt[i] <= '0;
        end else if (stab_cnt[i] + 1'b1 >= debounce_reg) begin
          filt[i]     <= sync2[i];
          stab_cnt[i] <= '0;
        end else begin
          stab_cnt[i] <= stab_cnt[i] + 1'b1;
        end
      end
    end
  end

  // Previous filtered levels for edge detection
  // Reset value equals the idle level of the filters, so no false edge
  // follows the release of reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_d <= 3'h0;
    end else begin
      filt_d <= filt;
    end
  end

  // Mode decode into up and down steps
  // Only filtered levels are decoded; the invert bit swaps the result
  // after decoding so every mode honours it the same way. Unused mode
  // codes count nothing.
  always_comb begin
    logic [1:0] st;
    logic       u;
    logic       d;
    st = qudc_step(filt_d[1:0], filt[1:0], mode == QUDC_QUAD);
    u  = 1'b0;
    d  = 1'b0;
    case (mode)
      QUDC_QUAD, QUDC_BIN: begin
        u = st[0];
        d = st[1];
      end
      QUDC_UDCNT: begin
        u = filt[0] & ~filt_d[0];
        d = filt[1] & ~filt_d[1];
      end
      QUDC_DIRCNT: begin
        u = filt[0] & ~filt_d[0] & ~filt[1];
        d = filt[0] & ~filt_d[0] & filt[1];
      end
      default: begin
        u = 1'b0;
        d = 1'b0;
      end
    endcase
    if (config_reg[QUDC_CFG_INVDIR_BIT]) begin
      up_step = enable & d;
      dn_step = enable & u;
    end else begin
      up_step = enable & u;
      dn_step = enable & d;
    end
  end

  // Boundary compare is signed; the flags stand as long as the count
  // lies outside the window, not only on the crossing step
  assign zero_edge = filt[2] & ~filt_d[2];
  assign over_max  = $signed(count) > $signed(max_bound);
  assign under_min = $signed(count) < $signed(min_bound);

  // Count update: bus write, zero marker, auto-zero, steps
  // Software load beats everything so a written value is never lost.
  // Auto-zero acts one cycle after the bound is passed, so the count
  // is briefly seen outside the window and the status bit records it.
  // A step in a zeroing cycle is dropped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 32'h0000_0000;
    end else if (wr_cfg && ph_addr == QUDC_COUNT_OFS) begin
      count <= hwdata;                                   // Software load
    end else if (enable && zero_edge && config_reg[QUDC_CFG_ZMRK_BIT]) begin
      count <= 32'h0000_0000;
    end else if (config_reg[QUDC_CFG_AUTOZ_BIT] && (over_max || under_min)) begin
      count <= 32'h0000_0000;
    end else if (up_step) begin
      count <= count + 32'h0000_0001;
    end else if (dn_step) begin
      count <= count - 32'h0000_0001;
    end
  end

  // Event pulses to the interval timer
  // Registered, so each pulse leaves on the edge that moves the count
  // and the timer sees exactly one pulse per step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_up_evt   <= 1'b0;
      count_down_evt <= 1'b0;
    end else begin
      count_up_evt   <= up_step;
      count_down_evt <= dn_step;
    end
  end

  // Events and clears
  // Clear bits come from the write-one-to-clear word in its data phase;
  // writing zero bits leaves those status bits alone
  always_comb begin
    set_ev = '0;
    set_ev[QUDC_ST_UP_BIT]   = up_step;
    set_ev[QUDC_ST_DOWN_BIT] = dn_step;
    set_ev[QUDC_ST_MAX_BIT]  = over_max;
    set_ev[QUDC_ST_MIN_BIT]  = under_min;
    set_ev[QUDC_ST_ZERO_BIT] = enable & zero_edge;
    clr_req = (wr_cfg && ph_addr == QUDC_CLEAR_OFS) ? hwdata[QUDC_ST_W-1:0] : '0;
  end

  // Sticky status: a set in the clearing cycle wins
  // An event that meets a clear is kept, so software never loses one;
  // a bound that is still exceeded sets its bit again at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_req) | set_ev;
    end
  end

  // Level interrupt from enabled status bits
  // Built from the next status, so the output follows a set or clear
  // on the same edge as the status itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~clr_req) | set_ev) & irq_en);
    end
  end

  // AHB-Lite address phase capture
  // hreadyout is tied high, so every transfer ends after one data phase.
  // Only the low address byte is decoded; higher bits alias.
  // hsize is not checked: every register is one whole word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel & htrans[1];
      ph_write <= hwrite;
      ph_addr  <= haddr[7:0];
    end
  end

  assign wr_cfg    = ph_valid & ph_write;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Writable registers
  // Writes land at the end of the data phase, while hwdata stands;
  // read-only and unmapped places ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg   <= QUDC_CONFIG_RST;
      debounce_reg <= QUDC_DEBOUNCE_RST[DEB_W-1:0];
      max_bound    <= QUDC_MAX_RST;
      min_bound    <= QUDC_MIN_RST;
      irq_en       <= '0;
    end else if (wr_cfg) begin
      if (ph_addr == QUDC_CONFIG_OFS) begin
        config_reg <= hwdata;
      end else if (ph_addr == QUDC_DEBOUNCE_OFS) begin
        debounce_reg <= hwdata[DEB_W-1:0];
      end else if (ph_addr == QUDC_MAX_OFS) begin
        max_bound <= hwdata;
      end else if (ph_addr == QUDC_MIN_OFS) begin
        min_bound <= hwdata;
      end else if (ph_addr == QUDC_IRQEN_OFS) begin
        irq_en <= hwdata[QUDC_ST_W-1:0];
      end
    end
  end

  // Read data, registered at the address phase
  // hrdata then stands through the whole data phase; the clear
  // register and unmapped places read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == QUDC_CONFIG_OFS) begin
        hrdata <= config_reg;
      end else if (haddr[7:0] == QUDC_DEBOUNCE_OFS) begin
        hrdata <= 32'(debounce_reg);
      end else if (haddr[7:0] == QUDC_COUNT_OFS) begin
        hrdata <= count;
      end else if (haddr[7:0] == QUDC_MAX_OFS) begin
        hrdata <= max_bound;
      end else if (haddr[7:0] == QUDC_MIN_OFS) begin
        hrdata <= min_bound;
      end else if (haddr[7:0] == QUDC_STATUS_OFS) begin
        hrdata <= 32'(status);
      end else if (haddr[7:0] == QUDC_IRQEN_OFS) begin
        hrdata <= 32'(irq_en);
      end else if (haddr[7:0] == QUDC_INPUTS_OFS) begin
        hrdata <= {29'h0, filt};
      end else begin
        hrdata <= 32'h0000_0000;                         // Unmapped reads zero
      end
    end
  end

endmodule // qudc_counter

// ### qudc_sva.sv
/* Port checker of the up/down counter.
   Assumes it is bound to qudc_counter and sees one clock, hclk. */
`timescale 1ns/1ps
module qudc_sva
  import qudc_pkg::*;
(
  input wire logic        hclk,           // Clock
  input wire logic        hresetn,        // Reset, low
  input wire logic        hsel,           // Select
  input wire logic [31:0] haddr,          // Address
  input wire logic [1:0]  htrans,         // Transfer
  input wire logic        hwrite,         // Write
  input wire logic        hready,         // Ready in
  input wire logic [31:0] hrdata,         // Read data
  input wire logic        hreadyout,      // Ready out
  input wire logic        hresp,          // Response
  input wire logic        pin_a,          // Pin a
  input wire logic        pin_b,          // Pin b
  input wire logic        pin_zero,       // Zero pin
  input wire logic        count_up_evt,   // Up event
  input wire logic        count_down_evt, // Down event
  input wire logic        irq             // Interrupt
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [9:0] quiet; // Cycles since any pin moved, saturating

  // Pins that rest long enough can no longer make a count step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      quiet <= 10'h000;
    else if ($changed({pin_a, pin_b, pin_zero}))
      quiet <= 10'h000;
    else if (quiet != 10'h3FF)
      quiet <= quiet + 10'h001;
  end

  // Read address phase of one register
  sequence rd_of(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == {24'h000000, a};
  endsequence

  chk_evt_exclusive: assert property (!(count_up_evt && count_down_evt))
    else $error("up and down events together");
  chk_quiet_noevt: assert property (quiet >= 10'h028 |-> !count_up_evt && !count_down_evt)
    else $error("count event with resting pins");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  chk_rst_quiet: assert property (disable iff (1'b0) !hresetn |-> !irq && !count_up_evt && !count_down_evt)
    else $error("output active in reset");
  chk_unmapped_zero: assert property (rd_of(8'h40) |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_status_width: assert property (rd_of(QUDC_STATUS_OFS) |=> hrdata[31:5] == 27'h0000000)
    else $error("status upper bits set");
  chk_inputs_width: assert property (rd_of(QUDC_INPUTS_OFS) |=> hrdata[31:3] == 29'h00000000)
    else $error("input levels upper bits set");
endmodule // qudc_sva

bind qudc_counter qudc_sva chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_a(pin_a),
  .pin_b(pin_b), .pin_zero(pin_zero), .count_up_evt(count_up_evt), .count_down_evt(count_down_evt), .irq(irq));

// ### qudc_encoder_model.sv
/* Behavioural quadrature encoder with a zero marker pin.
   Assumes the bench calls its tasks; pins move just after hclk rises. */
`timescale 1ns/1ps
module qudc_encoder_model (
  input  wire logic clk,     // System clock
  output logic      pin_a,   // Phase a
  output logic      pin_b,   // Phase b
  output logic      pin_zero // Zero marker or button
);
  int         hold = 12;    // Cycles each level stands
  logic [1:0] ph   = 2'b00; // Position in the gray cycle

  // Encoder at rest at phase zero
  initial begin
    {pin_zero, pin_b, pin_a} = 3'h0;
  end

  // Drive {zero, b, a} after an edge, then hold it
  task automatic put(input logic [2:0] v);
    @(posedge clk);
    {pin_zero, pin_b, pin_a} <= v;
    repeat (hold) @(posedge clk);
  endtask

  // One gray step, a single phase changes
  task automatic step(input logic up);
    ph = up ? ph + 2'b01 : ph - 2'b01;
    put({pin_zero, ph[1], ph[1] ^ ph[0]});
  endtask
endmodule // qudc_encoder_model

// ### tb_top.sv
/* Self-checking bench of the up/down counter.
   Assumes qudc_counter, the encoder model and a 20 MHz hclk. */
`timescale 1ns/1ps
module tb_top;
  import qudc_pkg::*;
  logic        hclk = 1'b0;         // System clock
  logic        hresetn = 1'b0;      // Reset, active low
  logic        hsel = 1'b0;         // Slave select
  logic [31:0] haddr = 32'h0;       // Address
  logic [1:0]  htrans = 2'b00;      // Transfer type
  logic        hwrite = 1'b0;       // Write flag
  logic [2:0]  hsize = 3'h0;        // Transfer size, word
  logic [31:0] hwdata = 32'h0;      // Write data
  logic [31:0] hrdata, q;           // Read data, last word read
  logic        hreadyout, hresp;    // Slave answer
  logic        pin_a, pin_b, pin_z; // Encoder pins
  logic        up_evt, dn_evt, irq; // Events and interrupt
  int          miscompares = 0;     // Mismatches
  int          checked = 0;         // Comparisons
  int          ups = 0, dns = 0;    // Event pulses seen
  int          cyc = 0;             // Cycles run

  always #25 hclk = ~hclk; // 50 ns period

  qudc_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_a(pin_a), .pin_b(pin_b), .pin_zero(pin_z), .count_up_evt(up_evt), .count_down_evt(dn_evt), .irq(irq));
  qudc_encoder_model enc (.clk(hclk), .pin_a(pin_a), .pin_b(pin_b), .pin_zero(pin_z));

  // Count event pulses; a run far past its length is cut short
  always @(posedge hclk) begin
    ups += int'(up_evt === 1'b1);
    dns += int'(dn_evt === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic play(input logic [2:0] s [$]);
    foreach (s[i]) enc.put(s[i]);
  endtask

  task automatic t_regs(); // Values after reset, unmapped place
    rc("config", QUDC_CONFIG_OFS, QUDC_CONFIG_RST);
    rc("debounce", QUDC_DEBOUNCE_OFS, QUDC_DEBOUNCE_RST);
    rc("count", QUDC_COUNT_OFS, 32'h0);
    rc("max", QUDC_MAX_OFS, QUDC_MAX_RST);
    rc("min", QUDC_MIN_OFS, QUDC_MIN_RST);
    rc("irqen", QUDC_IRQEN_OFS, 32'h0);
    rc("status", QUDC_STATUS_OFS, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_glitch(); // Short pulse rejected, long one counted
    bus(1'b1, QUDC_CONFIG_OFS, 32'h1);
    bus(1'b1, QUDC_DEBOUNCE_OFS, 32'h8);
    enc.hold = 3;
    enc.put(3'b001);
    enc.hold = 12;
    enc.put(3'b000);
    rc("glitch", QUDC_COUNT_OFS, 32'h0);
    enc.step(1'b1);
    rc("filtered", QUDC_COUNT_OFS, 32'h1);
    enc.step(1'b0);
    bus(1'b1, QUDC_DEBOUNCE_OFS, 32'h4);
  endtask

  task automatic t_quad(); // Gray steps both ways, events, sticky bits
    int u = ups;
    int d = dns;
    repeat (4) enc.step(1'b1);
    repeat (6) enc.step(1'b0);
    rc("quad", QUDC_COUNT_OFS, 32'hFFFFFFFE);
    chk("ups", 32'h4, ups - u);
    chk("downs", 32'h6, dns - d);
    rc("status", QUDC_STATUS_OFS, 32'h3);
    bus(1'b1, QUDC_CLEAR_OFS, 32'h1F);
    rc("cleared", QUDC_STATUS_OFS, 32'h0);
  endtask

  task automatic t_modes(); // Binary code, edge pair, edge with level
    bus(1'b1, QUDC_COUNT_OFS, 32'h0);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h3);
    play('{3'b010, 3'b001, 3'b000});
    rc("binary", QUDC_COUNT_OFS, 32'hFFFFFFFD);
    bus(1'b1, QUDC_COUNT_OFS, 32'h0);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h5);
    play('{3'b001, 3'b000, 3'b010, 3'b000, 3'b001, 3'b000});
    rc("updown", QUDC_COUNT_OFS, 32'h1);
    bus(1'b1, QUDC_COUNT_OFS, 32'h0);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h7);
    play('{3'b001, 3'b000, 3'b001, 3'b000, 3'b010, 3'b011, 3'b010, 3'b000});
    rc("direction", QUDC_COUNT_OFS, 32'h1);
    enc.ph = 2'b00;
    bus(1'b1, QUDC_COUNT_OFS, 32'h0);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h41);
    repeat (2) enc.step(1'b1);
    rc("inverted", QUDC_COUNT_OFS, 32'hFFFFFFFE);
  endtask

  task automatic t_bound(); // Interrupt, mask, then auto-zero both sides
    bus(1'b1, QUDC_COUNT_OFS, 32'h0);
    bus(1'b1, QUDC_MAX_OFS, 32'h2);
    bus(1'b1, QUDC_IRQEN_OFS, 32'h4);
    bus(1'b1, QUDC_CLEAR_OFS, 32'h1F);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h1);
    repeat (3) enc.step(1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, QUDC_CLEAR_OFS, 32'h4);
    rc("sticky", QUDC_STATUS_OFS, 32'h5);
    bus(1'b1, QUDC_IRQEN_OFS, 32'h0);
    repeat (2) @(posedge hclk); // irq is registered
    chk("masked", 32'h0, {31'h0, irq});
    bus(1'b1, QUDC_MIN_OFS, 32'hFFFFFFFF);
    bus(1'b1, QUDC_COUNT_OFS, 32'h0);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h11);
    repeat (3) enc.step(1'b1);
    rc("above", QUDC_COUNT_OFS, 32'h0);
    repeat (2) enc.step(1'b0);
    rc("below", QUDC_COUNT_OFS, 32'h0);
  endtask

  task automatic t_zero(); // Zero marker edge clears the count
    bus(1'b1, QUDC_MAX_OFS, QUDC_MAX_RST);
    bus(1'b1, QUDC_CONFIG_OFS, 32'h21);
    bus(1'b1, QUDC_COUNT_OFS, 32'h5);
    bus(1'b1, QUDC_CLEAR_OFS, 32'h1F);
    enc.put({1'b1, pin_b, pin_a});
    rc("inputs", QUDC_INPUTS_OFS, {29'h0, 1'b1, pin_b, pin_a});
    enc.put({1'b0, pin_b, pin_a});
    rc("zeroed", QUDC_COUNT_OFS, 32'h0);
    rc("marker", QUDC_STATUS_OFS, 32'h10);
  endtask

  initial begin : main
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_glitch();
    t_quad();
    t_modes();
    t_bound();
    t_zero();
    results();
  end
endmodule // tb_top
